//--- payload_pkg.sv
package payload_pkg;

  // widths of the payload path
  localparam int REG_W = 256;
  localparam int COEF_W = 16;
  localparam int IDX_W = 8;
  localparam int CFG_W = 6;
  localparam logic [3:0] WORDS_PER_REG_LAST = 4'hF;

  // register byte offsets on the apb side
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LAYOUT = 8'h04;
  localparam logic [7:0] OFS_BLOCKS = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_MV32_BIT = 2;

  // layout register fields, each CFG_W bits wide
  localparam int LAYOUT_M_LSB = 0;
  localparam int LAYOUT_P_LSB = 8;
  localparam int LAYOUT_Q_LSB = 16;

  // status register fields
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_DONE_BIT = 1;
  localparam int STATUS_ERR_BIT = 2;
  localparam int STATUS_LAST_LSB = 8;

  // values after reset
  localparam logic [CFG_W-1:0] RST_M = 6'h00;
  localparam logic [CFG_W-1:0] RST_P = 6'h04;
  localparam logic [CFG_W-1:0] RST_Q = 6'h06;
  localparam logic [5:0] RST_CODED = 6'h00;
  localparam logic RST_MODE = 1'b0;
  localparam logic RST_MV32 = 1'b1;

  // payload placement constants
  localparam logic [IDX_W-1:0] HDR_IDX = 8'h00;
  localparam logic [IDX_W-1:0] CONST_FIRST_IDX = 8'h01;
  localparam logic [IDX_W-1:0] COEF_BASE_IDX = 8'h02;
  localparam logic [IDX_W-1:0] SECTION_BIAS = 8'h02;
  localparam logic [1:0] BLOCK_REGS_LAST = 2'h3;
  localparam logic [2:0] LAST_BLOCK = 3'h5;
  localparam logic [2:0] MV_REGS_32 = 3'h4;
  localparam logic [2:0] MV_REGS_16 = 3'h2;
  localparam logic [6:0] WGT_REGS = 7'h02;
  localparam logic [6:0] RES_REGS = 7'h0C;
  localparam logic [6:0] ONE_REG = 7'h01;

  // section that the sequencer is filling
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_HDR,
    ST_CONST,
    ST_INL,
    ST_MV,
    ST_WGT,
    ST_RES,
    ST_COEF
  } sec_t;

endpackage : payload_pkg

//--- coef_row_packer.sv
`timescale 1ns/100ps

module coef_row_packer
  import payload_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic clear,
  input wire logic coef_valid,
  input wire logic [COEF_W-1:0] coef_data,
  output logic coef_ready,
  output logic reg_valid,
  output logic [REG_W-1:0] reg_data,
  input wire logic reg_ready
);

  logic [3:0] word_pos;
  logic take;

  // no new coefficients while a full register waits; keeps the buffer single
  assign coef_ready = ce && !reg_valid && !clear;
  assign take = coef_valid && coef_ready;

  // word slot from a running count of the coefficients taken
  // row-major input: word = (row & 1) * 8 + col, register = row / 2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_pos <= 4'h0;
      reg_data <= '0;
    end else if (ce) begin
      if (clear) begin
        word_pos <= 4'h0;
      end else if (take) begin
        reg_data[word_pos*COEF_W +: COEF_W] <= coef_data;
        word_pos <= word_pos + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_valid <= 1'b0;
    end else if (ce) begin
      if (clear) begin
        reg_valid <= 1'b0;
      end else if (take && word_pos == WORDS_PER_REG_LAST) begin
        reg_valid <= 1'b1;
      end else if (reg_ready) begin
        reg_valid <= 1'b0;
      end
    end
  end

  property p_pack_full;
    @(posedge pclk) disable iff (!presetn)
    (take && word_pos == WORDS_PER_REG_LAST)
      |=> (reg_valid && reg_data[REG_W-1 -: COEF_W] == $past(coef_data));
  endproperty
  a_pack_full: assert property (p_pack_full)
    else $error("register not presented after sixteenth coefficient");

  property p_word14;
    @(posedge pclk) disable iff (!presetn)
    (take && word_pos == 4'hE) |=> (reg_data[14*COEF_W +: COEF_W] == $past(coef_data));
  endproperty
  a_word14: assert property (p_word14)
    else $error("row 7 column 6 not in word 14");

endmodule : coef_row_packer

//--- payload_builder.sv
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps

module payload_builder
  import payload_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_valid,
  input wire logic [REG_W-1:0] in_data,
  output logic in_ready,
  input wire logic coef_valid,
  input wire logic [COEF_W-1:0] coef_data,
  output logic coef_ready,
  output logic out_valid,
  output logic [IDX_W-1:0] out_index,
  output logic [REG_W-1:0] out_data,
  input wire logic out_ready
);

  // configuration and status
  logic mode_it;
  logic mv32;
  logic [CFG_W-1:0] m_cfg;
  logic [CFG_W-1:0] p_cfg;
  logic [CFG_W-1:0] q_cfg;
  logic [5:0] coded;
  logic done;
  logic cfg_err;
  logic [IDX_W-1:0] last_idx;

  // sequencer
  sec_t sec;
  sec_t out_sec;
  logic [CFG_W-1:0] cnt;
  logic [2:0] blk;
  logic [1:0] blk_reg;
  logic [IDX_W-1:0] coef_idx;

  logic access;
  logic wr;
  logic mapped;
  logic busy;
  logic start_req;
  logic start_ok;
  logic [2:0] n_regs;
  logic [6:0] len;
  logic [IDX_W-1:0] base;
  logic it_sec;
  logic can_load;
  logic take_in;
  logic take_coef;
  logic reg_ready_m;
  logic pk_valid;
  logic [REG_W-1:0] pk_data;
  logic adv_it;
  logic coef_fin;
  logic finish;
  logic blk_coded;
  logic [31:0] rd_word;

  // size of the vector area from the vector size setting
  function automatic logic [2:0] mv_regs(input logic big);
    return big ? MV_REGS_32 : MV_REGS_16;
  endfunction : mv_regs

  // registers that a section occupies
  function automatic logic [6:0] sec_len(input sec_t s, input logic [CFG_W-1:0] m,
                                         input logic [2:0] n);
    case (s)
      ST_HDR: return ONE_REG;
      ST_CONST: return {1'b0, m};
      ST_INL: return ONE_REG;
      ST_MV: return {4'h0, n};
      ST_WGT: return WGT_REGS;
      ST_RES: return RES_REGS;
      default: return 7'h00;
    endcase
  endfunction : sec_len

  // first register index of a section
  function automatic logic [IDX_W-1:0] sec_base(input sec_t s, input logic [CFG_W-1:0] m,
                                                input logic [CFG_W-1:0] p,
                                                input logic [CFG_W-1:0] q);
    case (s)
      ST_HDR: return HDR_IDX;
      ST_CONST: return CONST_FIRST_IDX;
      ST_INL: return IDX_W'({2'b00, m}) + CONST_FIRST_IDX;
      ST_MV: return IDX_W'({2'b00, m}) + SECTION_BIAS;
      ST_WGT: return IDX_W'({2'b00, m}) + IDX_W'({2'b00, p}) + SECTION_BIAS;
      ST_RES: return IDX_W'({2'b00, m}) + IDX_W'({2'b00, q}) + SECTION_BIAS;
      default: return HDR_IDX;
    endcase
  endfunction : sec_base

  // fixed section order of the inverse-transform payload
  function automatic sec_t next_sec(input sec_t s);
    case (s)
      ST_HDR: return ST_CONST;
      ST_CONST: return ST_INL;
      ST_INL: return ST_MV;
      ST_MV: return ST_WGT;
      ST_WGT: return ST_RES;
      default: return ST_IDLE;
    endcase
  endfunction : next_sec

  // number of coded blocks in the pattern
  function automatic logic [2:0] coded_count(input logic [5:0] v);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 0; i < 6; i++) begin
      c = c + {2'b00, v[i]};
    end
    return c;
  endfunction : coded_count

  // apb decode; pready follows ce so a frozen block stalls the bus
  assign pready = ce;
  assign access = psel && penable && ce;
  assign wr = access && pwrite;
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_LAYOUT) || (paddr == OFS_BLOCKS) ||
                  (paddr == OFS_STATUS);
  assign pslverr = access && !mapped;
  assign busy = (sec != ST_IDLE);
  assign start_req = wr && paddr == OFS_CTRL && pwdata[CTRL_START_BIT] && !busy;
  assign n_regs = mv_regs(mv32);
  assign start_ok = start_req && (!pwdata[CTRL_MODE_BIT] ||
                    ({1'b0, p_cfg} >= {4'h0, mv_regs(pwdata[CTRL_MV32_BIT])} &&
                     {1'b0, q_cfg} >= {1'b0, p_cfg} + 7'h02));

  // read mux, sampled in the setup cycle so prdata is a flop
  always_comb begin
    rd_word = 32'h00000000;
    case (paddr)
      OFS_CTRL: begin
        rd_word[CTRL_MODE_BIT] = mode_it;
        rd_word[CTRL_MV32_BIT] = mv32;
      end
      OFS_LAYOUT: begin
        rd_word[LAYOUT_M_LSB +: CFG_W] = m_cfg;
        rd_word[LAYOUT_P_LSB +: CFG_W] = p_cfg;
        rd_word[LAYOUT_Q_LSB +: CFG_W] = q_cfg;
      end
      OFS_BLOCKS: rd_word[5:0] = coded;
      OFS_STATUS: begin
        rd_word[STATUS_BUSY_BIT] = busy;
        rd_word[STATUS_DONE_BIT] = done;
        rd_word[STATUS_ERR_BIT] = cfg_err;
        rd_word[STATUS_LAST_LSB +: IDX_W] = last_idx;
      end
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (ce && psel && !penable) begin
      prdata <= rd_word;
    end
  end

  // configuration writes; refused while a payload is being built
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_it <= RST_MODE;
      mv32 <= RST_MV32;
      m_cfg <= RST_M;
      p_cfg <= RST_P;
      q_cfg <= RST_Q;
      coded <= RST_CODED;
    end else if (wr && !busy) begin
      if (paddr == OFS_CTRL) begin
        mode_it <= pwdata[CTRL_MODE_BIT];
        mv32 <= pwdata[CTRL_MV32_BIT];
      end
      if (paddr == OFS_LAYOUT) begin
        m_cfg <= pwdata[LAYOUT_M_LSB +: CFG_W];
        p_cfg <= pwdata[LAYOUT_P_LSB +: CFG_W];
        q_cfg <= pwdata[LAYOUT_Q_LSB +: CFG_W];
      end
      if (paddr == OFS_BLOCKS) begin
        coded <= pwdata[5:0];
      end
    end
  end

  // status flags; a start cannot meet a finish since start needs idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
      cfg_err <= 1'b0;
    end else if (ce) begin
      if (finish) begin
        done <= 1'b1;
      end else if (start_ok) begin
        done <= 1'b0;
      end
      if (start_req) begin
        cfg_err <= !start_ok;
      end
    end
  end

  coef_row_packer u_packer (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .clear(start_ok),
    .coef_valid(coef_valid),
    .coef_data(coef_data),
    .coef_ready(coef_ready),
    .reg_valid(pk_valid),
    .reg_data(pk_data),
    .reg_ready(reg_ready_m)
  );

  // handshake terms of the sequencer
  assign len = sec_len(sec, m_cfg, n_regs);
  assign base = sec_base(sec, m_cfg, p_cfg, q_cfg);
  assign it_sec = (sec == ST_HDR) || (sec == ST_CONST) || (sec == ST_INL) || (sec == ST_MV) ||
                  (sec == ST_WGT) || (sec == ST_RES);
  assign can_load = !out_valid || out_ready;
  assign in_ready = ce && it_sec && ({1'b0, cnt} < len) && can_load;
  assign take_in = in_valid && in_ready;
  assign blk_coded = coded[blk];
  assign reg_ready_m = ce && sec == ST_COEF && blk_coded && can_load;
  assign take_coef = pk_valid && reg_ready_m;
  assign adv_it = ce && it_sec &&
                  ({1'b0, cnt} >= len || (take_in && {1'b0, cnt} + 7'h01 == len));
  assign coef_fin = ce && sec == ST_COEF && blk == LAST_BLOCK &&
                    (!blk_coded || (take_coef && blk_reg == BLOCK_REGS_LAST));
  assign finish = (adv_it && sec == ST_RES) || coef_fin;

  // inverse-transform section walk
  // empty constant area skipped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec <= ST_IDLE;
      cnt <= '0;
    end else if (ce) begin
      if (sec == ST_IDLE) begin
        if (start_ok) begin
          sec <= pwdata[CTRL_MODE_BIT] ? ST_HDR : ST_COEF;
        end
        cnt <= '0;
      end else if (adv_it) begin
        sec <= next_sec(sec);
        cnt <= '0;
      end else if (take_in) begin
        cnt <= cnt + 6'h01;
      end else if (coef_fin) begin
        sec <= ST_IDLE;
      end
    end
  end

  // coefficient block walk
  // uncoded block skipped in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk <= 3'h0;
      blk_reg <= 2'h0;
      coef_idx <= COEF_BASE_IDX;
    end else if (ce) begin
      if (sec == ST_IDLE) begin
        blk <= 3'h0;
        blk_reg <= 2'h0;
        coef_idx <= COEF_BASE_IDX;
      end else if (sec == ST_COEF) begin
        if (!blk_coded) begin
          blk <= blk + 3'h1;
        end else if (take_coef) begin
          coef_idx <= coef_idx + 8'h01;
          blk_reg <= blk_reg + 2'h1;
          if (blk_reg == BLOCK_REGS_LAST) begin
            blk <= blk + 3'h1;
          end
        end
      end
    end
  end

  // output register toward the thread register file
  // header index from section base
  // inline and vectors by base plus count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_index <= HDR_IDX;
      out_data <= '0;
      out_sec <= ST_IDLE;
      last_idx <= HDR_IDX;
    end else if (ce) begin
      if (take_in) begin
        out_valid <= 1'b1;
        out_index <= base + IDX_W'({2'b00, cnt});
        out_data <= in_data;
        out_sec <= sec;
        last_idx <= base + IDX_W'({2'b00, cnt});
      end else if (take_coef) begin
        out_valid <= 1'b1;
        out_index <= coef_idx;
        out_data <= pk_data;
        out_sec <= ST_COEF;
        last_idx <= coef_idx;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end

  property p_hdr_idx;
    @(posedge pclk) disable iff (!presetn)
    (out_valid && out_sec == ST_HDR) |-> (out_index == HDR_IDX);
  endproperty
  a_hdr_idx: assert property (p_hdr_idx)
    else $error("header not at register 0");

  property p_const_idx;
    @(posedge pclk) disable iff (!presetn)
    (out_valid && out_sec == ST_CONST) |-> (m_cfg != 6'h00 && out_index >= CONST_FIRST_IDX &&
                                            out_index <= {2'b00, m_cfg});
  endproperty
  a_const_idx: assert property (p_const_idx)
    else $error("constant outside 1..m");

  property p_inl_idx;
    @(posedge pclk) disable iff (!presetn)
    (out_valid && out_sec == ST_INL) |-> (out_index == {2'b00, m_cfg} + 8'h01);
  endproperty
  a_inl_idx: assert property (p_inl_idx)
    else $error("inline data not at m+1");

  property p_mv_idx;
    @(posedge pclk) disable iff (!presetn)
    (out_valid && out_sec == ST_MV) |-> (out_index >= {2'b00, m_cfg} + 8'h02 &&
                                         out_index <= {2'b00, m_cfg} + {5'h00, n_regs} + 8'h01);
  endproperty
  a_mv_idx: assert property (p_mv_idx)
    else $error("vector register outside its area");

  property p_wgt_idx;
    @(posedge pclk) disable iff (!presetn)
    (out_valid && out_sec == ST_WGT) |-> (out_index == base_wgt() || out_index == base_wgt() + 8'h01);
  endproperty
  a_wgt_idx: assert property (p_wgt_idx)
    else $error("weight-offset register inside gap");

  property p_res_idx;
    @(posedge pclk) disable iff (!presetn)
    (out_valid && out_sec == ST_RES) |-> (out_index >= base_res() &&
                                          out_index <= base_res() + 8'h0B);
  endproperty
  a_res_idx: assert property (p_res_idx)
    else $error("residual register inside gap");

  property p_coef_range;
    @(posedge pclk) disable iff (!presetn)
    (out_valid && out_sec == ST_COEF) |-> (out_index >= COEF_BASE_IDX &&
                                           out_index <= 8'h01 + {3'h0, coded_count(coded), 2'b00});
  endproperty
  a_coef_range: assert property (p_coef_range)
    else $error("coefficient register past 1+4x");

  property p_skip;
    @(posedge pclk) disable iff (!presetn)
    (ce && sec == ST_COEF && !blk_coded && blk != LAST_BLOCK) |=> (blk == $past(blk) + 3'h1 &&
                                                                   coef_idx == $past(coef_idx));
  endproperty
  a_skip: assert property (p_skip)
    else $error("uncoded block consumed a register");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    (out_valid && !out_ready) |=> (out_valid && $stable(out_data) && $stable(out_index));
  endproperty
  a_hold: assert property (p_hold)
    else $error("output changed while stalled");

  c_coef_done: cover property (@(posedge pclk) disable iff (!presetn) coef_fin);
  c_it_done: cover property (@(posedge pclk) disable iff (!presetn) adv_it && sec == ST_RES);
  c_skip: cover property (@(posedge pclk) disable iff (!presetn)
                          ce && sec == ST_COEF && !blk_coded);
  c_refused: cover property (@(posedge pclk) disable iff (!presetn) start_req && !start_ok);

  function automatic logic [IDX_W-1:0] base_wgt();
    return sec_base(ST_WGT, m_cfg, p_cfg, q_cfg);
  endfunction : base_wgt

  function automatic logic [IDX_W-1:0] base_res();
    return sec_base(ST_RES, m_cfg, p_cfg, q_cfg);
  endfunction : base_res

endmodule : payload_builder

//--- thread_reg_sink.sv
`timescale 1ns/100ps

module thread_reg_sink
  import payload_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stall_en,
  input wire logic out_valid,
  input wire logic [IDX_W-1:0] out_index,
  input wire logic [REG_W-1:0] out_data,
  output logic out_ready
);
  logic [IDX_W-1:0] got_idx[$];
  logic [REG_W-1:0] got_data[$];

  // random back-pressure, so the builder has to hold each word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= !stall_en || ($urandom_range(3) != 0);
    end
  end

  // record every word taken; the bench judges placement
  // gaps never relied on
  always @(posedge pclk) begin
    if (presetn && out_valid && out_ready) begin
      got_idx.push_back(out_index);
      got_data.push_back(out_data);
    end
  end
endmodule : thread_reg_sink

//--- tb_payload_builder.sv
`timescale 1ns/100ps

module tb_payload_builder;
  import payload_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, last_err;
  logic in_valid, in_ready, coef_valid, coef_ready, out_valid, out_ready;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [REG_W-1:0] in_data, out_data;
  logic [COEF_W-1:0] coef_data;
  logic [IDX_W-1:0] out_index;
  int num_errors, comparisons;
  logic [REG_W-1:0] exp_data[$];
  logic [REG_W-1:0] wq[$];
  logic [IDX_W-1:0] exp_idx[$];
  logic [COEF_W-1:0] cq[$];
  logic [5:0] pats[4] = '{6'h3F, 6'h00, 6'h20, 6'h05};

  payload_builder payload_builder_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .coef_valid(coef_valid), .coef_data(coef_data),
    .coef_ready(coef_ready), .out_valid(out_valid), .out_index(out_index),
    .out_data(out_data), .out_ready(out_ready));

  thread_reg_sink thread_reg_sink_i (.pclk(pclk), .presetn(presetn), .stall_en(1'b1),
    .out_valid(out_valid), .out_index(out_index), .out_data(out_data),
    .out_ready(out_ready));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task end_sim();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task check(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // ready is sampled at the very rising edge at which the design takes the request
  task wait_hi(input int sel);
    int k;
    k = 0;
    @(posedge pclk);
    while ((sel == 0 ? pready : sel == 1 ? in_ready : coef_ready) !== 1'b1) begin
      k++;
      if (k >= 5000) begin
        num_errors++;
        end_sim();
      end
      @(posedge pclk);
    end
    last_err = pslverr;
  endtask : wait_hi

  // one idle edge after release keeps psel from being assigned twice in a step
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    wait_hi(0);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // coefficient index of word k in block register r
  function automatic int coef_pos(input int r, input int k);
    if (r == 3 && k == 14) return 7 * 8 + 6;
    return (2 * r + k / 8) * 8 + k % 8;
  endfunction : coef_pos

  function automatic logic [IDX_W-1:0] it_index(input int k, m, p, q, n);
    if (k <= m + 1 + n) return IDX_W'(k);
    if (k < m + n + 4) return IDX_W'(m + p + 2 + k - (m + n + 2));
    return IDX_W'(m + q + 2 + k - (m + n + 4));
  endfunction : it_index

  task finish_run();
    int k;
    k = 0;
    while (thread_reg_sink_i.got_idx.size() < exp_idx.size() && k < 5000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 5000) begin
      num_errors++;
      end_sim();
    end
    // extra cycles catch stray or gap words
    repeat (6) @(posedge pclk);
    check(thread_reg_sink_i.got_idx.size(), exp_idx.size());
    foreach (exp_idx[i]) begin
      if (i < thread_reg_sink_i.got_idx.size()) begin
        check(thread_reg_sink_i.got_idx[i], exp_idx[i]);
        check(thread_reg_sink_i.got_data[i], exp_data[i]);
      end
    end
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd[STATUS_ERR_BIT], 1'b0);
    if (exp_idx.size() > 0) begin
      check({rd[STATUS_DONE_BIT], rd[15:8]}, {1'b1, exp_idx[$]});
    end
    thread_reg_sink_i.got_idx.delete();
    thread_reg_sink_i.got_data.delete();
    exp_idx.delete();
    exp_data.delete();
  endtask : finish_run

  task coef_test(input logic [5:0] pat);
    logic [COEF_W-1:0] blk[64];
    logic [REG_W-1:0] w;
    cq.delete();
    for (int b = 0; b < 6; b++) begin
      if (pat[b]) begin
        for (int i = 0; i < 64; i++) begin
          blk[i] = COEF_W'($urandom);
          cq.push_back(blk[i]);
        end
        for (int r = 0; r < 4; r++) begin
          for (int k = 0; k < 16; k++) w[16 * k +: 16] = blk[coef_pos(r, k)];
          exp_idx.push_back(IDX_W'(2 + exp_idx.size()));
          exp_data.push_back(w);
        end
      end
    end
    apb(1'b1, OFS_BLOCKS, {26'h0, pat});
    apb(1'b1, OFS_CTRL, 32'h5);
    foreach (cq[i]) begin
      coef_valid <= 1'b1;
      coef_data <= cq[i];
      wait_hi(2);
    end
    coef_valid <= 1'b0;
    finish_run();
  endtask : coef_test

  task it_test(input int m, p, q, input logic mv);
    int n;
    n = mv ? 4 : 2;
    wq.delete();
    for (int k = 0; k < 16 + m + n; k++) begin
      wq.push_back({8{$urandom}});
      exp_idx.push_back(it_index(k, m, p, q, n));
      exp_data.push_back(wq[$]);
    end
    apb(1'b1, OFS_LAYOUT, {10'h0, 6'(q), 2'h0, 6'(p), 2'h0, 6'(m)});
    apb(1'b1, OFS_CTRL, {29'h0, mv, 2'h3});
    foreach (wq[i]) begin
      in_valid <= 1'b1;
      in_data <= wq[i];
      wait_hi(1);
    end
    in_valid <= 1'b0;
    finish_run();
  endtask : it_test

  // a refused start must set err and emit nothing
  task bad_test(input int p, q);
    apb(1'b1, OFS_LAYOUT, {10'h0, 6'(q), 2'h0, 6'(p), 8'h0});
    apb(1'b1, OFS_CTRL, 32'h7);
    repeat (10) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    check({rd[STATUS_ERR_BIT], 8'(thread_reg_sink_i.got_idx.size())}, {1'b1, 8'h00});
  endtask : bad_test

  initial begin
    #(40 * 90000);
    num_errors++;
    end_sim();
  end

  initial begin
    int m, p, mv;
    void'($urandom(8649));
    {presetn, ce, psel, penable, pwrite, in_valid, coef_valid} = 7'h00;
    {paddr, pwdata, in_data, coef_data} = '0;
    num_errors = 0;
    comparisons = 0;
    ce = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_LAYOUT, 32'h0);
    check(rd, 32'h00060400);
    apb(1'b0, OFS_CTRL, 32'h0);
    check(rd, 32'h00000004);
    apb(1'b0, 8'h10, 32'h0);
    check({last_err, rd}, {1'b1, 32'h0});
    // a frozen block holds pready low, so the write must wait for ce
    ce <= 1'b0;
    fork
      apb(1'b1, OFS_BLOCKS, 32'h0000002A);
      begin
        repeat (4) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    apb(1'b0, OFS_BLOCKS, 32'h0);
    check(rd, 32'h0000002A);
    foreach (pats[i]) begin
      coef_test(pats[i]);
    end
    repeat (3) coef_test(6'($urandom));
    it_test(0, 4, 6, 1'b1);
    it_test(0, 2, 4, 1'b0);
    it_test(3, 6, 11, 1'b1);
    bad_test(3, 6);
    bad_test(4, 5);
    repeat (3) begin
      m = $urandom_range(3);
      mv = $urandom_range(1);
      p = (mv ? 4 : 2) + $urandom_range(2);
      it_test(m, p, p + 2 + $urandom_range(2), mv[0]);
    end
    end_sim();
  end
endmodule : tb_payload_builder
